// >>> mii_pcs_defs.svh
`ifndef MII_PCS_DEFS_SVH
`define MII_PCS_DEFS_SVH

// Widths
`define NIB_W            4
`define CG_W             5
`define SCR_W            11

// Scrambler x^11 + x^9 + 1: taps on bits 10 and 8
`define SCR_TAP_HI       10
`define SCR_TAP_LO       8
`define SCR_SEED         11'h7ff

// Code groups, bit 4 sent first
`define CG_IDLE          5'h1f
`define CG_J             5'h18
`define CG_K             5'h11
`define CG_T             5'h0d
`define CG_R             5'h07
`define CG_H             5'h04
// Data code groups, nibble f down to nibble 0
`define CG_TABLE {5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h17, 5'h16, 5'h13, 5'h12, \
	5'h0f, 5'h0e, 5'h0b, 5'h0a, 5'h15, 5'h14, 5'h09, 5'h1e}

// Nibble handed to the MAC in place of each start delimiter symbol
`define PREAMBLE_NIB     4'h5

// Timing: symbols per nibble period, reference period and system clock
`define SYMS_PER_GROUP   5
`define REF_PERIOD_NS    800
`define CLK_PERIOD_NS    100
`define CLKS_PER_NIBBLE  (`REF_PERIOD_NS / `CLK_PERIOD_NS)

`define RX_FIFO_DEPTH    8

// MLT-3 phase codes: 0, +1, 0, -1
`define MLT_PH_POS       2'h1
`define MLT_PH_NEG       2'h3

`endif

// >>> mii_pcs_pkg.sv
`include "mii_pcs_defs.svh"

package mii_pcs_pkg;

	typedef enum logic [2:0] {
		SYM_IDLE = 3'h0,
		SYM_J    = 3'h1,
		SYM_K    = 3'h2,
		SYM_DATA = 3'h3,
		SYM_T    = 3'h4,
		SYM_R    = 3'h5,
		SYM_BAD  = 3'h6
	} sym_kind_t;

	typedef enum logic [1:0] {
		TX_IDLE  = 2'h0,
		TX_SFD_K = 2'h1,
		TX_DATA  = 2'h2,
		TX_ESD_R = 2'h3
	} tx_state_t;

	typedef struct packed {
		logic              en;
		logic              er;
		logic [`NIB_W-1:0] d;
	} mii_tx_t;

	typedef struct packed {
		logic              dv;
		logic              er;
		logic [`NIB_W-1:0] d;
	} mii_rx_t;

	typedef struct packed {
		sym_kind_t         kind;
		logic [`NIB_W-1:0] nib;
	} rx_sym_t;

	typedef struct packed {
		logic pos;
		logic neg;
	} mlt_t;

endpackage

// >>> mii_100tx_pcs_encoder.sv
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
// Receive symbol buffer between the decode chain and the MII
module sync_fifo #(
	parameter int W     = 7,
	parameter int DEPTH = `RX_FIFO_DEPTH
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
			$error("sync_fifo depth must be a power of two, at least 2");
		end
	endgenerate

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
		logic                    rdy;
	} fifo_st_t;

	fifo_st_t s_reg;
	fifo_st_t s_next;
	logic     push;
	logic     pop;

	always_comb begin
		s_next = s_reg;
		push   = in_valid & s_reg.rdy;
		pop    = out_ready & (s_reg.cnt != '0);
		if (push) begin
			s_next.mem[s_reg.wp] = in_data;
			s_next.wp            = s_reg.wp + 1'b1;
		end
		if (pop) begin
			s_next.rp = s_reg.rp + 1'b1;
		end
		s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
		// Registered ready keeps the source path free of our pop logic
		s_next.rdy = (s_next.cnt != (AW+1)'(DEPTH));
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign in_ready  = s_reg.rdy;
	assign out_data  = s_reg.mem[s_reg.rp];
	assign out_valid = (s_reg.cnt != '0);
endmodule

////////////////////////////////////////////////////////////////////////////
module mii_100tx_pcs_encoder
	import mii_pcs_pkg::*;
#(
	parameter int CLKS_PER_NIB = `CLKS_PER_NIBBLE,
	parameter int FIFO_DEPTH   = `RX_FIFO_DEPTH
) (
	input  wire logic    clk,
	input  wire logic    rst_b,
	input  wire logic    ref_clk,
	input  wire mii_tx_t mii_tx,
	input  wire logic    bypass_4b5b,
	input  wire rx_sym_t dec_sym,
	input  wire logic    dec_valid,
	output logic         dec_ready,
	output logic         tx_clk,
	output logic         rx_clk,
	output mii_rx_t      mii_rx,
	output logic         crs,
	output logic         tx_nrzi,
	output mlt_t         tx_mlt
);
	localparam int SYMS  = `SYMS_PER_GROUP;
	localparam int ACC_W = $clog2(CLKS_PER_NIB) + 1;
	localparam logic [`CG_W*16-1:0] CG_TBL = `CG_TABLE;

	generate
		if (CLKS_PER_NIB < SYMS || CLKS_PER_NIB < 4) begin : g_bad_ratio
			$error("need at least one system clock per symbol");
		end
	endgenerate

	typedef struct packed {
		logic                ref1;
		logic                ref2;
		logic                ref3;
		mii_tx_t             tx1;
		mii_tx_t             tx2;
		logic                byp1;
		logic                byp2;
		logic                clk_out;
		tx_state_t           st;
		logic                err_pend;
		logic [`SCR_W-1:0]   lfsr;
		logic [`CG_W-2:0]    sh;
		logic [2:0]          left;
		logic [ACC_W-1:0]    acc;
		logic                nrzi;
		logic [1:0]          ph;
		mlt_t                mlt;
		mii_rx_t             rx;
		logic                rx_act;
		logic                crs;
	} st_t;

	st_t s_reg;
	st_t s_next;

	// Data nibble to 5-bit code group
	function automatic logic [`CG_W-1:0] enc_4b5b(
		input logic [`NIB_W-1:0] nib
	);
		enc_4b5b = CG_TBL[int'(nib) * `CG_W +: `CG_W];
	endfunction

	// Advance the key generator one step per symbol of a group; the
	// first key bit lines up with code bit 4, the first one sent.
	function automatic logic [`CG_W+`SCR_W-1:0] scramble_step(
		input logic [`SCR_W-1:0] seed_in
	);
		logic [`SCR_W-1:0] st;
		logic [`CG_W-1:0]  key;
		logic              fb;
		st  = (seed_in == '0) ? `SCR_SEED : seed_in;
		key = '0;
		fb  = 1'b0;
		for (int i = `CG_W - 1; i >= 0; i--) begin
			fb     = st[`SCR_TAP_HI] ^ st[`SCR_TAP_LO];
			key[i] = fb;
			st     = {st[`SCR_W-2:0], fb};
		end
		scramble_step = {key, st};
	endfunction

	logic [`CG_W-1:0]  code;
	logic [`CG_W-1:0]  grp;
	logic [`CG_W-1:0]  key;
	logic [`SCR_W-1:0] lfsr_adv;
	logic [ACC_W-1:0]  acc_sum;
	logic              sym_tick;
	logic              emit;
	logic              bit_out;
	logic              take;
	logic              tx_busy;
	rx_sym_t           fifo_sym;
	logic [$bits(rx_sym_t)-1:0] fifo_data;
	logic              fifo_valid;

	sync_fifo #(
		.W     ($bits(rx_sym_t)),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.clk       (clk),
		.rst_b     (rst_b),
		.in_data   (dec_sym),
		.in_valid  (dec_valid),
		.in_ready  (dec_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (take)
	);

	assign fifo_sym = rx_sym_t'(fifo_data);

	always_comb begin
		s_next   = s_reg;
		code     = `CG_IDLE;
		grp      = '0;
		key      = '0;
		lfsr_adv = s_reg.lfsr;
		emit     = 1'b0;
		bit_out  = 1'b0;

		////////////////////////////////////////////////////////////////
		// Pin synchronisers; the first stage feeds only the second
		s_next.ref1 = ref_clk;
		s_next.ref2 = s_reg.ref1;
		s_next.ref3 = s_reg.ref2;
		s_next.tx1  = mii_tx;
		s_next.tx2  = s_reg.tx1;
		s_next.byp1 = bypass_4b5b;
		s_next.byp2 = s_reg.byp1;

		// Both MII clocks follow the reference and never stop
		s_next.clk_out = s_reg.ref2;

		// MAC changes data on our rising edge; sample on the falling one,
		// half a period later, when it has settled.
		take = s_reg.ref3 & ~s_reg.ref2;

		// Symbol ticks: SYMS per reference period, phase restarted on
		// every take so drift between the clocks cannot accumulate.
		acc_sum  = s_reg.acc + ACC_W'(SYMS);
		sym_tick = (acc_sum >= ACC_W'(CLKS_PER_NIB));

		////////////////////////////////////////////////////////////////
		// Transmit coding
		if (take) begin
			if (s_reg.byp2) begin
				// Fifth bit rides on the coding error line
				code = s_reg.tx2.en ? {s_reg.tx2.er, s_reg.tx2.d}
					: `CG_IDLE;
				s_next.st       = TX_IDLE;
				s_next.err_pend = 1'b0;
			end else begin
				unique case (s_reg.st)
					TX_IDLE: begin
						if (s_reg.tx2.en) begin
							code            = `CG_J;
							s_next.st       = TX_SFD_K;
							s_next.err_pend = s_reg.tx2.er;
						end else begin
							code = `CG_IDLE;
						end
					end
					TX_SFD_K: begin
						if (s_reg.tx2.en) begin
							code            = `CG_K;
							s_next.st       = TX_DATA;
							s_next.err_pend = s_reg.err_pend | s_reg.tx2.er;
						end else begin
							code      = `CG_T;
							s_next.st = TX_ESD_R;
						end
					end
					TX_DATA: begin
						if (s_reg.tx2.en) begin
							// An error seen during J/K is carried to here
							if (s_reg.tx2.er | s_reg.err_pend) begin
								code = `CG_H;
							end else begin
								code = enc_4b5b(s_reg.tx2.d);
							end
							s_next.err_pend = 1'b0;
						end else begin
							code      = `CG_T;
							s_next.st = TX_ESD_R;
						end
					end
					TX_ESD_R: begin
						code            = `CG_R;
						s_next.st       = TX_IDLE;
						s_next.err_pend = 1'b0;
					end
				endcase
			end
			{key, lfsr_adv} = scramble_step(s_reg.lfsr);
			grp             = code ^ key;
			s_next.lfsr     = lfsr_adv;
			// Bit 4 leaves at once; four more follow on the ticks
			emit        = 1'b1;
			bit_out     = grp[`CG_W-1];
			s_next.sh   = grp[`CG_W-2:0];
			s_next.left = 3'(SYMS - 1);
			s_next.acc  = '0;
		end else begin
			s_next.acc = sym_tick ? acc_sum - ACC_W'(CLKS_PER_NIB) : acc_sum;
			// An early take would cut a group short; the last tick comes one clock
			// before a nominal take, so a take even one clock early can cause that.
			if (sym_tick && s_reg.left != '0) begin
				emit        = 1'b1;
				bit_out     = s_reg.sh[`CG_W-2];
				s_next.sh   = {s_reg.sh[`CG_W-3:0], 1'b0};
				s_next.left = s_reg.left - 3'h1;
			end
		end

		// NRZI and MLT-3 move together on every serial one
		if (emit && bit_out) begin
			s_next.nrzi    = ~s_reg.nrzi;
			s_next.ph      = s_reg.ph + 2'h1;
			s_next.mlt.pos = (s_next.ph == `MLT_PH_POS);
			s_next.mlt.neg = (s_next.ph == `MLT_PH_NEG);
		end

		////////////////////////////////////////////////////////////////
		// Receive side: one decoded symbol per MII receive period,
		// presented on the falling edge of rx_clk.
		if (take) begin
			if (!fifo_valid) begin
				// Starved mid-frame: the nibble is lost, so flag it
				if (s_reg.rx.dv) begin
					s_next.rx.er = 1'b1;
				end
			end else begin
				unique case (fifo_sym.kind)
					SYM_J, SYM_K: begin
						s_next.rx.dv  = 1'b1;
						s_next.rx.er  = 1'b0;
						s_next.rx.d   = `PREAMBLE_NIB;
						s_next.rx_act = 1'b1;
					end
					SYM_DATA: begin
						s_next.rx_act = 1'b1;
						if (s_reg.rx.dv) begin
							s_next.rx.d  = fifo_sym.nib;
							s_next.rx.er = 1'b0;
						end
					end
					SYM_T, SYM_R: begin
						// End delimiter never shows as valid data
						s_next.rx.dv = 1'b0;
						s_next.rx.er = 1'b0;
					end
					SYM_IDLE: begin
						s_next.rx.dv  = 1'b0;
						s_next.rx.er  = 1'b0;
						s_next.rx_act = 1'b0;
					end
					default: begin
						s_next.rx_act = 1'b1;
						if (s_reg.rx.dv) begin
							s_next.rx.er = 1'b1;
						end
					end
				endcase
			end
		end

		tx_busy    = s_reg.tx2.en | (s_next.st != TX_IDLE);
		s_next.crs = tx_busy | s_next.rx_act;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_reg      <= '0;
			s_reg.lfsr <= `SCR_SEED;
		end else begin
			s_reg <= s_next;
		end
	end

	assign tx_clk  = s_reg.clk_out;
	assign rx_clk  = s_reg.clk_out;
	assign mii_rx  = s_reg.rx;
	assign crs     = s_reg.crs;
	assign tx_nrzi = s_reg.nrzi;
	assign tx_mlt  = s_reg.mlt;
endmodule

// >>> mii_100tx_pcs_encoder_assertions.sv
`timescale 1ns/1ns
module pcs_checker
	import mii_pcs_pkg::*;
#(
	parameter int CLKS_PER_NIB = 8,
	parameter int FIFO_DEPTH   = 8
) (
	input wire logic    clk,
	input wire logic    rst_b,
	input wire mii_tx_t mii_tx,
	input wire logic    tx_clk,
	input wire logic    rx_clk,
	input wire mii_rx_t mii_rx,
	input wire logic    crs,
	input wire logic    tx_nrzi,
	input wire mlt_t    tx_mlt
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// Remembers which side of the line drove the last nonzero level
	logic last_pos_reg;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			last_pos_reg <= 1'b0;
		else if (tx_mlt.pos)
			last_pos_reg <= 1'b1;
		else if (tx_mlt.neg)
			last_pos_reg <= 1'b0;
	end

	mlt_one_side_a: assert property (!(tx_mlt.pos && tx_mlt.neg))
		else $error("line drives both sides");
	mlt_tracks_nrzi_a: assert property ($changed(tx_nrzi) == $changed(tx_mlt))
		else $error("line step without nrzi toggle");
	pos_after_neg_a: assert property ($rose(tx_mlt.pos) |-> !last_pos_reg)
		else $error("positive level repeated");
	neg_after_pos_a: assert property ($rose(tx_mlt.neg) |-> last_pos_reg)
		else $error("negative level out of order");
	rx_clk_same_a: assert property (rx_clk == tx_clk)
		else $error("receive clock differs");
	tx_clk_high_a: assert property ($rose(tx_clk) |-> ##[3:5] $fell(tx_clk))
		else $error("clock high too long");
	tx_clk_low_a: assert property ($fell(tx_clk) |-> ##[3:5] $rose(tx_clk))
		else $error("clock low too long");
	rx_on_fall_a: assert property ($changed(mii_rx) |-> $fell(rx_clk))
		else $error("receive nibble off clock");
	er_in_frame_a: assert property ($rose(mii_rx.er) |-> mii_rx.dv)
		else $error("receive error outside frame");
	crs_on_tx_a: assert property ($rose(mii_tx.en) |-> ##[1:4] crs)
		else $error("no carrier on transmit");
	crs_on_rx_a: assert property (mii_rx.dv |-> crs)
		else $error("no carrier on receive");
endmodule

bind mii_100tx_pcs_encoder pcs_checker #(
	.CLKS_PER_NIB(CLKS_PER_NIB),
	.FIFO_DEPTH  (FIFO_DEPTH)
) pcs_checker_i (
	.clk(clk), .rst_b(rst_b), .mii_tx(mii_tx), .tx_clk(tx_clk),
	.rx_clk(rx_clk), .mii_rx(mii_rx), .crs(crs), .tx_nrzi(tx_nrzi),
	.tx_mlt(tx_mlt)
);

// >>> mac_model.sv
`timescale 1ns/1ns
module mac_model
	import mii_pcs_pkg::*;
(
	input wire logic tx_clk,
	output mii_tx_t  mii_tx
);
	initial mii_tx = '0;

	// Two preamble nibbles lead, then a count pattern
	task automatic send(input int len, input int er_at);
		for (int i = 0; i < len; i++) begin
			@(posedge tx_clk);
			mii_tx.en <= 1'b1;
			mii_tx.er <= (i == er_at);
			mii_tx.d  <= (i < 2) ? 4'h5 : i[3:0];
		end
		@(posedge tx_clk);
		// Released data shows the inverse, never a stale copy
		mii_tx <= {1'b0, 1'b0, ~mii_tx.d};
	endtask
endmodule

// >>> mii_100tx_pcs_encoder_test.sv
`timescale 1ns/1ns
`include "mii_pcs_defs.svh"
module mii_100tx_pcs_encoder_test
	import mii_pcs_pkg::*;
;
	typedef struct packed {
		rx_sym_t sym;
		mii_rx_t exp;
		logic    full;
	} rx_row_t;

	localparam rx_row_t ROWS [10] = '{
		'{'{SYM_J, 4'h0}, '{1'b1, 1'b0, 4'h5}, 1'b1},
		'{'{SYM_K, 4'h0}, '{1'b1, 1'b0, 4'h5}, 1'b1},
		'{'{SYM_DATA, 4'h3}, '{1'b1, 1'b0, 4'h3}, 1'b1},
		'{'{SYM_DATA, 4'ha}, '{1'b1, 1'b0, 4'ha}, 1'b1},
		'{'{SYM_BAD, 4'h0}, '{1'b1, 1'b1, 4'h0}, 1'b0},
		'{'{SYM_DATA, 4'hf}, '{1'b1, 1'b0, 4'hf}, 1'b1},
		'{'{SYM_T, 4'h0}, '{1'b0, 1'b0, 4'h0}, 1'b0},
		'{'{SYM_R, 4'h0}, '{1'b0, 1'b0, 4'h0}, 1'b0},
		'{'{SYM_DATA, 4'h7}, '{1'b0, 1'b0, 4'h0}, 1'b0},
		'{'{SYM_IDLE, 4'h0}, '{1'b0, 1'b0, 4'h0}, 1'b0}
	};

	logic    clk, rst_b, ref_clk, bypass_4b5b, dec_valid, dec_ready;
	logic    tx_clk, rx_clk, crs, tx_nrzi, saw_full;
	logic    [3:0] mask;
	rx_sym_t dec_sym;
	mii_tx_t mii_tx;
	mii_rx_t mii_rx;
	mlt_t    tx_mlt;
	int      fail_count, samples_checked;
	logic    [10:0] exp_lfsr;
	logic    [4:0] key, pend_grp;
	logic    [1:0] exp_ph;
	logic    prev_rx_clk, nrzi_q, exp_nrzi, pend_valid, idle_chk;
	mlt_t    mlt_q;

	mii_100tx_pcs_encoder mii_100tx_pcs_encoder_i (
		.clk(clk), .rst_b(rst_b), .ref_clk(ref_clk), .mii_tx(mii_tx),
		.bypass_4b5b(bypass_4b5b), .dec_sym(dec_sym), .dec_valid(dec_valid),
		.dec_ready(dec_ready), .tx_clk(tx_clk), .rx_clk(rx_clk),
		.mii_rx(mii_rx), .crs(crs), .tx_nrzi(tx_nrzi), .tx_mlt(tx_mlt)
	);
	mac_model mac_model_i (.tx_clk(tx_clk), .mii_tx(mii_tx));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Reference runs free, out of phase with the system clock
	initial begin
		ref_clk = 1'b0;
		#137;
		forever #400 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string n, input logic [5:0] e,
		input logic [5:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	// Waits for receive clock (sel 0) or carrier (sel 1) to reach v
	task automatic wait_for(input int sel, input logic v, input int lim);
		for (int i = 0; (sel ? crs : rx_clk) !== v; i++) begin
			if (i == lim) begin
				fail_count++;
				print_verdict();
			end
			@(negedge clk);
		end
	endtask

	// Key stream of one group, first key bit lines up with code bit 4
	function automatic logic [15:0] key_step(input logic [10:0] s);
		logic [4:0] k;
		for (int i = 4; i >= 0; i--) begin
			k[i] = s[10] ^ s[8];
			s = {s[9:0], k[i]};
		end
		key_step = {k, s};
	endfunction

	// Idle line model: each receive clock fall is a group boundary; the
	// line is read one clock before it, when the last group is complete.
	always @(negedge clk) begin
		if (!rst_b) begin
			exp_lfsr = `SCR_SEED;
			exp_ph = 2'h0;
			exp_nrzi = 1'b0;
			pend_valid = 1'b0;
			prev_rx_clk = 1'b0;
		end else begin
			if (prev_rx_clk && !rx_clk) begin
				if (pend_valid) begin
					exp_nrzi = exp_nrzi ^ (^pend_grp);
					exp_ph = exp_ph + 2'($countones(pend_grp));
					if (idle_chk) begin
						chk("nrzi", {5'h0, exp_nrzi}, {5'h0, nrzi_q});
						chk("mlt", {4'h0, exp_ph == 2'h1, exp_ph == 2'h3},
							{4'h0, mlt_q});
					end
				end
				{key, exp_lfsr} = key_step(exp_lfsr);
				pend_grp = `CG_IDLE ^ key;
				pend_valid = 1'b1;
			end
			prev_rx_clk = rx_clk;
		end
		nrzi_q = tx_nrzi;
		mlt_q = tx_mlt;
	end

	task automatic next_pop();
		wait_for(0, 1'b1, 20);
		wait_for(0, 1'b0, 20);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		rst_b = 1'b0;
		bypass_4b5b = 1'b0;
		dec_valid = 1'b0;
		dec_sym = '0;
		fail_count = 0;
		samples_checked = 0;
		idle_chk = 1'b1;
		repeat (10) @(negedge clk);
		rst_b = 1'b1;
		// Push just after a pop so the symbol waits for the next one
		next_pop();
		for (int r = 0; r < 10; r++) begin
			dec_sym = ROWS[r].sym;
			dec_valid = 1'b1;
			@(negedge clk);
			dec_valid = 1'b0;
			next_pop();
			mask = ROWS[r].full ? 4'hf : 4'h0;
			chk("rx", {ROWS[r].exp.dv, ROWS[r].exp.er, ROWS[r].exp.d & mask},
				{mii_rx.dv, mii_rx.er, mii_rx.d & mask});
		end
		// Idle symbols back to back for 12 clocks; the buffer must refuse one
		saw_full = 1'b0;
		dec_sym = '{SYM_IDLE, 4'h0};
		dec_valid = 1'b1;
		repeat (12) begin
			@(negedge clk);
			if (dec_ready === 1'b0)
				saw_full = 1'b1;
		end
		dec_valid = 1'b0;
		chk("full", 6'h1, 6'(saw_full));
		repeat (100) @(negedge clk);
		chk("drained", 6'h2, {4'h0, dec_ready, crs});
		// Frame with a coding error, then a bypass frame
		idle_chk = 1'b0;
		mac_model_i.send(16, 6);
		@(negedge clk);
		chk("crs_tx", 6'h1, 6'(crs));
		wait_for(1, 1'b0, 80);
		bypass_4b5b = 1'b1;
		mac_model_i.send(8, -1);
		wait_for(1, 1'b0, 80);
		bypass_4b5b = 1'b0;
		// Reset in mid-frame clears every output
		dec_sym = '{SYM_J, 4'h0};
		dec_valid = 1'b1;
		@(negedge clk);
		dec_valid = 1'b0;
		next_pop();
		rst_b = 1'b0;
		#10;
		chk("reset", 6'h0, {mii_rx.dv, crs, dec_ready, tx_mlt, tx_nrzi});
		@(negedge clk);
		rst_b = 1'b1;
		repeat (3) @(negedge clk);
		chk("ready", 6'h1, 6'(dec_ready));
		print_verdict();
	end
endmodule
